/* File: hdl/pmseq_regs.vh */
`ifndef PMSEQ_REGS_VH
`define PMSEQ_REGS_VH
// factory start-order byte and its fields
`define PMSEQ_CFG_BYTE        8'h02
`define PMSEQ_ORDER_MSB       7
`define PMSEQ_ORDER_LSB       5
`define PMSEQ_D1_MSB          4
`define PMSEQ_D1_LSB          3
`define PMSEQ_D2_MSB          2
`define PMSEQ_D2_LSB          0
// mode control bit positions
`define PMSEQ_SWRST_BIT       0
`define PMSEQ_SLEEP_BIT       6
`define PMSEQ_STBY_BIT        7
// delays in microseconds, as printed in ms
`define PMSEQ_D1_US0          240
`define PMSEQ_D1_US1          480
`define PMSEQ_D1_US2          960
`define PMSEQ_D1_US3          1200
`define PMSEQ_D2_US0          4800
`define PMSEQ_D2_US1          9600
`define PMSEQ_D2_US2          12000
`define PMSEQ_D2_US3          19200
`define PMSEQ_D2_US4          26400
`define PMSEQ_D2_US5          62400
`define PMSEQ_D2_US6          79200
`define PMSEQ_D2_US7          100800
// deglitch on the hardware reset pin, ms
`define PMSEQ_DEGLITCH_MS     5
// reset timer constant, us per nF, and default timing cap in nF
`define PMSEQ_KRESET_US_NF    1000
`define PMSEQ_CAP_NF          10
// clock rate in kHz (cycles per ms)
`define PMSEQ_CLK_KHZ         20000
// pg mask reset value: all masked
`define PMSEQ_PG_MASK_RST     8'hff
`endif

/* File: hdl/pmseq_sequencer.v */
// Contract
// - B7..B5 codes 000..010 pick start order
// - codes 011..110 orders, 111 disables sequencing
// - B4..B3 pick first delay 0.24-1.2 ms
// - B2..B0 pick second delay 4.8-100.8 ms
// - reset state: reset out low, cap timer
// - i2c engine held in reset while low
// - pg masked in reset; expiry goes pg check
// - irq driver off while reset out low
// - pg check: fault goes sleep else normal
// - mask hides fault, status still reports
// - normal: thermal/lowsys sleep, pg fault nopower
// - normal: soft or hard reset enters reset
// - normal: sleep bit enters sleep
// - sleep: reset out low, defaults restored
// - sleep: supplies off except backup regulator
// - thermal sleep exits only on uvlo
// - battery-only sleep: input gives enable
// - both present: input cycle gives enable
// - standby: bucks pfm at standby levels
// - hw reset low 5ms: reset out low
// - b0 reset, b6 sleep, registers kept
// - factory byte fixed at 0x02
// - command bits self clear after use
// - pg event on unmasked status change
`timescale 1ns/1ns
`include "pmseq_regs.vh"
module pmseq_sequencer #(
  parameter [7:0]  CFG_BYTE    = `PMSEQ_CFG_BYTE,
  parameter        CYC_PER_MS  = `PMSEQ_CLK_KHZ,
  parameter        CAP_NF      = `PMSEQ_CAP_NF,
  parameter [31:0] RESET_CYC   = (`PMSEQ_KRESET_US_NF * CAP_NF * CYC_PER_MS) / 1000,
  parameter [31:0] DEGL_CYC    = `PMSEQ_DEGLITCH_MS * CYC_PER_MS
) (
  input  wire       core_clk,
  input  wire       resetn,
  input  wire       clk_en,
  input  wire       uvlo_in,            // all sources below uvlo
  input  wire       ac_present_in,
  input  wire       usb_present_in,
  input  wire       bat_present_in,
  input  wire       sys_sense_in,       // high: system bus above low-sys threshold
  input  wire       thermal_fault_in,
  input  wire       hw_reset_in,        // active low pin
  input  wire [7:0] pg_status_in,       // 1 = out of regulation
  input  wire [7:0] pg_fault_mask,
  input  wire       sw_reset_wr,        // one-cycle write strobe of mode_control_reg
  input  wire [7:0] mode_control_wdata,
  input  wire       stby_gpio_in,
  input  wire       backup_reg_keep,
  input  wire       irq_pending_in,
  output reg        host_reset_out,
  output reg        i2c_reset_out,
  output reg        irq_n_oe,
  output reg        pg_cmp_en,
  output reg  [7:0] supply_en,          // {buck_a,buck_b,-,lin_a,lin_b,lin_c,lin_d,lin_e}
  output reg        backup_reg_en,
  output reg        restore_defaults,   // one-cycle pulse on sleep entry
  output reg        bucks_pfm,
  output reg        bucks_use_stby_lvl,
  output reg        pg_fault_event,     // one-cycle pulse
  output reg  [1:0] sleep_cause,
  output reg  [2:0] mode_state,
  output reg  [7:0] pg_status_out,
  output reg  [7:0] mode_control_rd
);
  // states
  localparam [2:0] ST_NOPWR = 3'd0, ST_ENABLE = 3'd1, ST_SEQ = 3'd2, ST_RESET = 3'd3;
  localparam [2:0] ST_PGCHK = 3'd4, ST_NORMAL = 3'd5, ST_SLEEP = 3'd6;
  // sleep causes
  localparam [1:0] CS_THERM = 2'd0, CS_LOWSYS = 2'd1, CS_PG = 2'd2, CS_SW = 2'd3;
  // supply groups
  localparam [7:0] GRP_LIN1 = 8'h13, GRP_BA_C = 8'h84, GRP_BB_B = 8'h48;
  localparam [7:0] GRP_LINS = 8'h1f, GRP_BA = 8'h80, GRP_BB = 8'h40;

  wire [2:0] order_code = CFG_BYTE[`PMSEQ_ORDER_MSB:`PMSEQ_ORDER_LSB];
  wire [1:0] d1_code    = CFG_BYTE[`PMSEQ_D1_MSB:`PMSEQ_D1_LSB];
  wire [2:0] d2_code    = CFG_BYTE[`PMSEQ_D2_MSB:`PMSEQ_D2_LSB];

  reg [31:0] d1_cyc;    // first delay in cycles
  reg [31:0] d2_cyc;    // second delay in cycles
  // delay tables; us figures scaled by clock rate
  always @* begin
    case (d1_code)
      2'd0:    d1_cyc = (`PMSEQ_D1_US0 * CYC_PER_MS) / 1000;
      2'd1:    d1_cyc = (`PMSEQ_D1_US1 * CYC_PER_MS) / 1000;
      2'd2:    d1_cyc = (`PMSEQ_D1_US2 * CYC_PER_MS) / 1000;
      default: d1_cyc = (`PMSEQ_D1_US3 * CYC_PER_MS) / 1000;
    endcase
    case (d2_code)
      3'd0:    d2_cyc = (`PMSEQ_D2_US0 * CYC_PER_MS) / 1000;
      3'd1:    d2_cyc = (`PMSEQ_D2_US1 * CYC_PER_MS) / 1000;
      3'd2:    d2_cyc = (`PMSEQ_D2_US2 * CYC_PER_MS) / 1000;
      3'd3:    d2_cyc = (`PMSEQ_D2_US3 * CYC_PER_MS) / 1000;
      3'd4:    d2_cyc = (`PMSEQ_D2_US4 * CYC_PER_MS) / 1000;
      3'd5:    d2_cyc = (`PMSEQ_D2_US5 * CYC_PER_MS) / 1000;
      3'd6:    d2_cyc = (`PMSEQ_D2_US6 * CYC_PER_MS) / 1000;
      default: d2_cyc = (`PMSEQ_D2_US7 * CYC_PER_MS) / 1000;
    endcase
  end

  reg [7:0] grp0, grp1, grp2;  // supplies of each start step
  // start order table
  always @* begin
    case (order_code)
      3'd0: begin
        grp0 = GRP_LIN1;
        grp1 = GRP_BA_C;
        grp2 = GRP_BB_B;
      end
      3'd1: begin
        grp0 = GRP_BA_C;
        grp1 = GRP_LIN1;
        grp2 = GRP_BB_B;
      end
      3'd2: begin
        grp0 = 8'hdf;
        grp1 = 8'h00;
        grp2 = 8'h00;
      end
      3'd3: begin
        grp0 = GRP_BA;
        grp1 = GRP_BB;
        grp2 = GRP_LINS;
      end
      3'd4: begin
        grp0 = GRP_BB;
        grp1 = GRP_BA;
        grp2 = GRP_LINS;
      end
      3'd5: begin
        grp0 = GRP_LINS;
        grp1 = GRP_BA;
        grp2 = GRP_BB;
      end
      3'd6: begin
        grp0 = GRP_LINS;
        grp1 = GRP_BB;
        grp2 = GRP_BA;
      end
      default: begin
        grp0 = 8'h00;
        grp1 = 8'h00;
        grp2 = 8'h00;
      end
    endcase
  end
  wire seq_off  = (order_code == 3'd7);
  wire seq_flat = (order_code == 3'd2);

  reg [2:0]  state_ff;      // operating mode
  reg [1:0]  step_ff;       // sequencing step
  reg [31:0] tmr_ff;        // shared mode timer
  reg [31:0] degl_ff;       // hw reset low counter
  reg        hw_armed_ff;   // deglitch passed, waiting for rising edge
  reg        hw_prev_ff;    // last pin level for edge detect
  reg [7:0]  pg_prev_ff;    // last unmasked status
  reg        sw_rst_ff;     // pending soft reset
  reg        sw_slp_ff;     // pending sleep request
  reg        stby_ff;       // register standby bit
  reg        both_gone_ff;  // both inputs seen removed during sleep
  reg        inp_prev_ff;   // input present last cycle

  wire [7:0] pg_unmasked = pg_status_in & ~pg_fault_mask;
  wire       pg_fault    = |pg_unmasked;
  wire       inp_now     = ac_present_in | usb_present_in;
  wire       hw_rise     = hw_reset_in & ~hw_prev_ff;

  reg [2:0]  nxt_state;
  reg [1:0]  nxt_cause;
  // mode transitions
  always @* begin
    nxt_state = state_ff;
    nxt_cause = sleep_cause;
    case (state_ff)
      ST_NOPWR:  if (!uvlo_in) nxt_state = ST_ENABLE;
      ST_ENABLE: if (sys_sense_in) nxt_state = ST_SEQ;
      ST_SEQ:    if (seq_off || seq_flat || (step_ff == 2'd2 && tmr_ff == 32'd0))
                   nxt_state = ST_RESET;
      ST_RESET:  if (tmr_ff == 32'd0) nxt_state = ST_PGCHK;
      ST_PGCHK: begin
        if (pg_fault) begin
          nxt_state = ST_SLEEP;
          nxt_cause = CS_PG;
        end else begin
          nxt_state = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (thermal_fault_in) begin
          nxt_state = ST_SLEEP;
          nxt_cause = CS_THERM;
        end else if (!sys_sense_in) begin
          nxt_state = ST_SLEEP;
          nxt_cause = CS_LOWSYS;
        end else if (pg_fault) begin
          nxt_state = ST_NOPWR;
        end else if (sw_rst_ff || hw_rise && hw_armed_ff) begin
          nxt_state = ST_RESET;
        end else if (sw_slp_ff) begin
          nxt_state = ST_SLEEP;
          nxt_cause = CS_SW;
        end
      end
      ST_SLEEP: begin
        if (uvlo_in) nxt_state = ST_NOPWR;
        else if (sleep_cause != CS_THERM) begin
          if (!bat_present_in || !inp_prev_ff || both_gone_ff) begin
            if (inp_now && (sleep_cause != CS_PG || both_gone_ff))
              nxt_state = ST_ENABLE;
          end
        end
      end
      default: nxt_state = ST_NOPWR;
    endcase
    if (uvlo_in) nxt_state = ST_NOPWR;
  end

  // next host reset level; i2c and irq follow it in the same cycle so
  // neither is free for even one clock while the host is held
  wire nxt_host = (nxt_state == ST_PGCHK || nxt_state == ST_NORMAL) &&
                  !(!hw_reset_in && degl_ff >= DEGL_CYC) && !hw_armed_ff;

  // mode register, timers and outputs
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_NOPWR;
      step_ff <= 2'd0;
      tmr_ff <= 32'd0;
      degl_ff <= 32'd0;
      hw_armed_ff <= 1'b0;
      hw_prev_ff <= 1'b1;
      pg_prev_ff <= 8'h00;
      sw_rst_ff <= 1'b0;
      sw_slp_ff <= 1'b0;
      stby_ff <= 1'b0;
      both_gone_ff <= 1'b0;
      inp_prev_ff <= 1'b0;
      host_reset_out <= 1'b0;
      i2c_reset_out <= 1'b1;
      irq_n_oe <= 1'b0;
      pg_cmp_en <= 1'b0;
      supply_en <= 8'h00;
      backup_reg_en <= 1'b0;
      restore_defaults <= 1'b0;
      bucks_pfm <= 1'b0;
      bucks_use_stby_lvl <= 1'b0;
      pg_fault_event <= 1'b0;
      sleep_cause <= CS_THERM;
      mode_state <= ST_NOPWR;
      pg_status_out <= 8'h00;
      mode_control_rd <= 8'h00;
    end else if (clk_en) begin
      state_ff    <= nxt_state;
      sleep_cause <= nxt_cause;
      mode_state  <= nxt_state;
      hw_prev_ff  <= hw_reset_in;
      inp_prev_ff <= inp_now;
      // command bits: set wins, cleared once consumed
      if (sw_reset_wr && mode_control_wdata[`PMSEQ_SWRST_BIT]) sw_rst_ff <= 1'b1;
      else if (state_ff != ST_NORMAL || nxt_state == ST_RESET) sw_rst_ff <= 1'b0;
      if (sw_reset_wr && mode_control_wdata[`PMSEQ_SLEEP_BIT]) sw_slp_ff <= 1'b1;
      else if (state_ff != ST_NORMAL || nxt_state == ST_SLEEP) sw_slp_ff <= 1'b0;
      if (sw_reset_wr) stby_ff <= mode_control_wdata[`PMSEQ_STBY_BIT];
      mode_control_rd <= {stby_ff, sw_slp_ff, 5'd0, sw_rst_ff};
      // hw reset deglitch, counted in cycles
      if (hw_reset_in) degl_ff <= 32'd0;
      else if (degl_ff < DEGL_CYC) degl_ff <= degl_ff + 32'd1;
      if (!hw_reset_in && degl_ff >= DEGL_CYC) hw_armed_ff <= 1'b1;
      else if (hw_rise) hw_armed_ff <= 1'b0;
      // timer load on state or step change
      if (nxt_state == ST_RESET && state_ff != ST_RESET) begin
        tmr_ff <= RESET_CYC;
      end else if (nxt_state == ST_SEQ && state_ff != ST_SEQ) begin
        tmr_ff <= d1_cyc; step_ff <= 2'd0;
      end else if (state_ff == ST_SEQ && tmr_ff == 32'd0 && step_ff != 2'd2) begin
        step_ff <= step_ff + 2'd1;
        tmr_ff  <= (step_ff == 2'd0) ? d2_cyc : 32'd0;
      end else if (tmr_ff != 32'd0) begin
        tmr_ff <= tmr_ff - 32'd1;
      end
      // supply enables
      if (nxt_state == ST_SEQ || state_ff == ST_SEQ)
        supply_en <= supply_en | grp0 |
                     ((state_ff == ST_SEQ && step_ff != 2'd0) ? grp1 : 8'h00) |
                     ((state_ff == ST_SEQ && step_ff == 2'd2) ? grp2 : 8'h00);
      else if (nxt_state == ST_SLEEP || nxt_state == ST_NOPWR)
        supply_en <= 8'h00;
      backup_reg_en <= (nxt_state == ST_SLEEP) ? backup_reg_keep : (nxt_state != ST_NOPWR);
      // host reset: high only in pg check and normal, low once deglitch passes
      host_reset_out <= nxt_host;
      i2c_reset_out  <= !nxt_host;
      // irq only while reset out high
      irq_n_oe <= nxt_host && irq_pending_in;
      pg_cmp_en <= (nxt_state == ST_PGCHK || nxt_state == ST_NORMAL);
      restore_defaults <= (nxt_state == ST_SLEEP && state_ff != ST_SLEEP);
      bucks_pfm <= (state_ff == ST_NORMAL) && (stby_ff || stby_gpio_in);
      bucks_use_stby_lvl <= (state_ff == ST_NORMAL) && (stby_ff || stby_gpio_in);
      pg_status_out <= pg_cmp_en ? pg_status_in : 8'h00;
      pg_prev_ff <= pg_unmasked;
      pg_fault_event <= pg_cmp_en && (pg_unmasked != pg_prev_ff);
      // input power cycle tracking while asleep
      if (state_ff != ST_SLEEP) both_gone_ff <= 1'b0;
      else if (!inp_now) both_gone_ff <= 1'b1;
    end
  end
endmodule

/* File: sim/pmseq_monitor.sv */
`timescale 1ns/1ns
module pmseq_monitor (
  input wire       core_clk,
  input wire       resetn,
  input wire       thermal_fault_in,
  input wire       uvlo_in,
  input wire       hw_reset_in,
  input wire [7:0] pg_status_in,
  input wire [7:0] pg_fault_mask,
  input wire       host_reset_out,
  input wire       i2c_reset_out,
  input wire       irq_n_oe,
  input wire [7:0] supply_en,
  input wire       pg_fault_event,
  input wire [1:0] sleep_cause,
  input wire [2:0] mode_state,
  input wire [7:0] mode_control_rd
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // states held two edges so registered outputs have caught up
  wire slp = (mode_state == 3'h6);
  wire hlo = !host_reset_out;
  property p_i2c; hlo && !$past(host_reset_out) |-> i2c_reset_out; endproperty
  a_i2c: assert property (p_i2c) else $error("i2c engine free in host reset");
  property p_irq; hlo && !$past(host_reset_out) |-> !irq_n_oe; endproperty
  a_irq: assert property (p_irq) else $error("irq driven in host reset");
  property p_off; slp && $past(slp) |-> supply_en == 8'h00 && hlo; endproperty
  a_off: assert property (p_off) else $error("supply or host live in sleep");
  property p_rst; mode_state == 3'h3 && $past(mode_state) == 3'h3 |-> hlo; endproperty
  a_rst: assert property (p_rst) else $error("host released in reset state");
  property p_nrm;
    mode_state == 3'h5 && $past(mode_state) == 3'h5 && hw_reset_in && $past(hw_reset_in)
      |-> host_reset_out;
  endproperty
  a_nrm: assert property (p_nrm) else $error("host held in normal");
  property p_thm; mode_state == 3'h5 && thermal_fault_in |-> ##[1:4] slp; endproperty
  a_thm: assert property (p_thm) else $error("thermal fault ignored");
  // thermal sleep only ends through uvlo
  property p_hold; slp && $past(slp) && sleep_cause == 2'h0 && !uvlo_in |=> slp; endproperty
  a_hold: assert property (p_hold) else $error("thermal sleep left early");
  property p_clr; mode_control_rd[0] |-> ##[1:4] !mode_control_rd[0]; endproperty
  a_clr: assert property (p_clr) else $error("reset bit stuck");
  property p_pge;
    mode_state == 3'h5 && ((pg_status_in ^ $past(pg_status_in)) & ~pg_fault_mask) != 8'h00
      |-> ##[0:3] pg_fault_event;
  endproperty
  a_pge: assert property (p_pge) else $error("pg event missing");
  c_sw: cover property (slp && sleep_cause == 2'h3);
  c_th: cover property (slp && sleep_cause == 2'h0);
  c_rs: cover property (mode_state == 3'h3);
endmodule
bind pmseq_sequencer pmseq_monitor pmseq_monitor_inst (.*);

/* File: sim/pmseq_host_model.sv */
`timescale 1ns/1ns
module pmseq_host_model (
  input  wire       core_clk,
  input  wire       host_reset_out,
  output reg        sw_reset_wr,
  output reg  [7:0] mode_control_wdata
);
  initial begin
    sw_reset_wr = 1'b0;
    mode_control_wdata = 8'h00;
  end
  // one register write; idle data shows the inverse so stale bytes never match
  task write_mode(input [7:0] data, input integer gap);
    begin
      wait (host_reset_out === 1'b1);
      repeat (gap + 1) @(negedge core_clk);
      sw_reset_wr = 1'b1;
      mode_control_wdata = data;
      @(negedge core_clk);
      sw_reset_wr = 1'b0;
      mode_control_wdata = ~data;
    end
  endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  reg        core_clk, resetn, uvlo_in, ac_in, usb_in, sys_ok, therm, hw_rst_n;
  reg  [7:0] pg_st, pg_mask;
  reg        clk_en, bat, stby_g, bkp_keep, irq_pend;
  wire       irq_oe, pg_cmp, bkp_en, rst_def, pfm, stby_lvl, pg_evt;
  wire [7:0] pg_out;
  wire       sw_wr, host_rst, i2c_rst;
  wire [7:0] wdata, supply_en, mode_rd;
  wire [1:0] cause;
  wire [2:0] st;
  integer    n_errors, tests_run;
  // short ms so the 12 ms second delay is 1200 cycles
  pmseq_sequencer #(.CYC_PER_MS(100), .CAP_NF(1), .RESET_CYC(32'd20), .DEGL_CYC(32'd50))
    pmseq_sequencer_inst (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .uvlo_in(uvlo_in), .ac_present_in(ac_in), .usb_present_in(usb_in),
    .bat_present_in(bat), .sys_sense_in(sys_ok), .thermal_fault_in(therm),
    .hw_reset_in(hw_rst_n), .pg_status_in(pg_st), .pg_fault_mask(pg_mask),
    .sw_reset_wr(sw_wr), .mode_control_wdata(wdata), .stby_gpio_in(stby_g),
    .backup_reg_keep(bkp_keep), .irq_pending_in(irq_pend), .host_reset_out(host_rst),
    .i2c_reset_out(i2c_rst), .irq_n_oe(irq_oe), .pg_cmp_en(pg_cmp), .supply_en(supply_en),
    .backup_reg_en(bkp_en), .restore_defaults(rst_def), .bucks_pfm(pfm),
    .bucks_use_stby_lvl(stby_lvl), .pg_fault_event(pg_evt), .sleep_cause(cause),
    .mode_state(st), .pg_status_out(pg_out),
    .mode_control_rd(mode_rd));
  pmseq_host_model host_inst (.core_clk(core_clk), .host_reset_out(host_rst),
    .sw_reset_wr(sw_wr), .mode_control_wdata(wdata));
  task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // bounded poll each cycle, then let outputs settle
  task wait_st(input [2:0] s);
    integer n;
    begin
      n = 0;
      while (st !== s && n < 4000) begin
        @(negedge core_clk);
        n = n + 1;
      end
      chk("mode_state", {5'h00, s}, {5'h00, st});
      repeat (2) @(negedge core_clk);
    end
  endtask
  task t_powerup;
    begin
      uvlo_in = 1'b0;
      wait_st(3'h3);
      chk("host_reset", 8'h00, {7'h00, host_rst});
      chk("supply_en", 8'hdf, supply_en);
      wait_st(3'h5);
      chk("i2c_reset", 8'h00, {7'h00, i2c_rst});
      $display("test powerup done");
    end
  endtask
  // irq, standby, pg status and clock enable seen from normal mode
  task t_misc;
    begin
      irq_pend = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("irq_oe", 8'h01, {7'h00, irq_oe});
      irq_pend = 1'b0;
      stby_g = 1'b1;
      pg_st = 8'h80;
      repeat (2) @(negedge core_clk);
      chk("pfm", 8'h01, {7'h00, pfm});
      chk("stby_lvl", 8'h01, {7'h00, stby_lvl});
      chk("pg_cmp", 8'h01, {7'h00, pg_cmp});
      chk("pg_out", 8'h80, pg_out);
      chk("mode_state", 8'h05, {5'h00, st});
      stby_g = 1'b0;
      pg_st = 8'h00;
      clk_en = 1'b0;
      repeat (3) @(negedge core_clk);
      chk("pfm_frozen", 8'h01, {7'h00, pfm});
      clk_en = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("pfm", 8'h00, {7'h00, pfm});
      chk("pg_evt", 8'h00, {7'h00, pg_evt});
      $display("test misc done");
    end
  endtask
  task t_swreset;
    begin
      host_inst.write_mode(8'h01, 3);
      wait_st(3'h3);
      chk("host_reset", 8'h00, {7'h00, host_rst});
      wait_st(3'h5);
      chk("mode_rd", 8'h00, mode_rd);
      $display("test swreset done");
    end
  endtask
  task t_sleep;
    begin
      host_inst.write_mode(8'h40, 0);
      wait_st(3'h6);
      chk("cause", 8'h03, {6'h00, cause});
      chk("supply_en", 8'h00, supply_en);
      chk("host_reset", 8'h00, {7'h00, host_rst});
      chk("backup_en", 8'h01, {7'h00, bkp_en});
      chk("restore_def", 8'h00, {7'h00, rst_def});
      ac_in = 1'b1;
      wait_st(3'h1);
      wait_st(3'h5);
      $display("test sleep done");
    end
  endtask
  task t_thermal;
    begin
      therm = 1'b1;
      wait_st(3'h6);
      chk("cause", 8'h00, {6'h00, cause});
      therm = 1'b0;
      ac_in = 1'b0;
      repeat (5) @(negedge core_clk);
      ac_in = 1'b1;
      repeat (20) @(negedge core_clk);
      chk("mode_state", 8'h06, {5'h00, st});
      uvlo_in = 1'b1;
      wait_st(3'h0);
      t_powerup;
      $display("test thermal done");
    end
  endtask
  task t_hwreset;
    begin
      hw_rst_n = 1'b0;
      repeat (60) @(negedge core_clk);
      chk("host_reset", 8'h00, {7'h00, host_rst});
      hw_rst_n = 1'b1;
      wait_st(3'h3);
      wait_st(3'h5);
      $display("test hwreset done");
    end
  endtask
  task t_pgfault;
    begin
      pg_mask = 8'hfe;
      pg_st = 8'h02;
      repeat (5) @(negedge core_clk);
      chk("mode_state", 8'h05, {5'h00, st});
      pg_st = 8'h03;
      wait_st(3'h0);
      pg_st = 8'h00;
      wait_st(3'h5);
      $display("test pgfault done");
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    {resetn, ac_in, usb_in, therm} = 4'h0;
    {uvlo_in, sys_ok, hw_rst_n} = 3'h7;
    pg_st = 8'h00;
    pg_mask = 8'hff;
    {clk_en, bat, stby_g, bkp_keep, irq_pend} = 5'h1a;
    n_errors = 0;
    tests_run = 0;
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    t_powerup;
    t_misc;
    t_swreset;
    t_sleep;
    t_thermal;
    t_hwreset;
    t_pgfault;
    end_of_test;
  end
  // about 5200 cycles expected
  initial begin
    #(40000 * 50);
    n_errors = n_errors + 1;
    end_of_test;
  end
endmodule
